// ==== hdl/msp_decoder.sv ====
// Purpose: message select port and configuration switch decoder
// Assumes: port pins and switch asynchronous; CFG_* inputs from same-clock logic
// Notes:   RST_B is the restart button path; long counts are parameters
`timescale 1ns/10ps
`include "msp_map.svh"

module msp_decoder #(
   parameter int unsigned SCAN_CYC     = `MSP_SCAN_CYC,
   parameter int unsigned DEBOUNCE_CYC = `MSP_DEBOUNCE_CYC,
   parameter int unsigned SELFTEST_CYC = `MSP_SELFTEST_CYC
) (
   input  wire logic                CLK_SYS,
   input  wire logic                RST_B,
   input  wire logic [7:0]          CONFIG_DIP_SWITCH,
   input  wire logic [15:0]         SELECT_BIT,
   input  wire logic                CTRL_HOLD,
   input  wire logic                CTRL_MSG_DATA,
   input  wire logic                CTRL_SET_SEL1,
   input  wire logic                CTRL_SET_SEL2,
   input  wire logic                CFG_WIDE16,
   input  wire logic                CFG_INVERT,
   input  wire logic                CFG_BCD,
   output logic                     SELF_TESTING,
   output msp_pkg::msp_mode_e       MODE,
   output msp_pkg::msp_baud_e       BAUD_SEL,
   output logic                     FRAME_INTERNAL,
   output logic                     FRAME_ODD_7BIT,
   output logic [15:0]              MSG_NUM,
   output logic                     MSG_STB,
   output logic [15:0]              DATA_VAL,
   output logic [1:0]               DATA_SET,
   output logic                     DATA_STB
);

   localparam logic [23:0] QUAL_CNT = 24'(SCAN_CYC + DEBOUNCE_CYC);
   localparam logic [23:0] SCAN_TOP = 24'(SCAN_CYC - 1);
   localparam logic [23:0] TEST_TOP = 24'(SELFTEST_CYC - 1);

   function automatic logic digit_bad(input logic [3:0] d);
      digit_bad = (d > 4'h9);
   endfunction

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // three stages; a bit takes its new level once stages two and three agree
   logic [27:0] sy1_q, sy2_q, sy3_q, pins_q;
   wire  [27:0] pins_raw = {CONFIG_DIP_SWITCH, CTRL_SET_SEL2, CTRL_SET_SEL1,
                            CTRL_MSG_DATA, CTRL_HOLD, SELECT_BIT};
   wire  [27:0] agree    = ~(sy2_q ^ sy3_q);
   wire  [27:0] pins_d   = (agree & sy3_q) | (~agree & pins_q);

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         sy1_q  <= 28'h0000000;
         sy2_q  <= 28'h0000000;
         sy3_q  <= 28'h0000000;
         pins_q <= 28'h0000000;
      end else begin
         sy1_q  <= pins_raw;
         sy2_q  <= sy1_q;
         sy3_q  <= sy2_q;
         pins_q <= pins_d;
      end
   end

   wire [7:0]  sw  = pins_q[27:20];
   wire [19:0] act = pins_q[19:0];

   // ---------------------------------------------------------------
   // restart, self test and switch decode
   // ---------------------------------------------------------------
   msp_pkg::msp_state_e state_q, state_d;
   logic [23:0]         test_q;
   wire                 test_done = (state_q == msp_pkg::MSP_ST_TEST) && (test_q == TEST_TOP);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         msp_pkg::MSP_ST_TEST: begin
            if (test_done) begin
               state_d = msp_pkg::MSP_ST_RUN;
            end
         end
         msp_pkg::MSP_ST_RUN: begin
            state_d = msp_pkg::MSP_ST_RUN;
         end
         default: begin
            state_d = msp_pkg::MSP_ST_TEST;
         end
      endcase
   end

   wire msp_pkg::msp_mode_e mode_sw = msp_pkg::msp_mode_e'(sw[`MSP_SW_MODE_HI:`MSP_SW_MODE_LO]);
   wire msp_pkg::msp_baud_e baud_sw = sw[`MSP_SW_BAUD_INT]  ? msp_pkg::MSP_BAUD_INTERNAL :
                                      sw[`MSP_SW_BAUD_1200] ? msp_pkg::MSP_BAUD_1200 :
                                      msp_pkg::MSP_BAUD_300;
   wire frame_int_sw = sw[`MSP_SW_BAUD_INT];
   wire frame_alt_sw = !sw[`MSP_SW_BAUD_INT] && sw[`MSP_SW_FRAME];

   // switch is latched only once, at the end of self test: later changes wait for restart
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_q        <= msp_pkg::MSP_ST_TEST;
         test_q         <= 24'h000000;
         SELF_TESTING   <= 1'b1;
         MODE           <= msp_pkg::msp_mode_e'(`MSP_MODE_RST);
         BAUD_SEL       <= msp_pkg::MSP_BAUD_300;
         FRAME_INTERNAL <= 1'b0;
         FRAME_ODD_7BIT <= 1'b0;
      end else begin
         state_q      <= state_d;
         test_q       <= test_done ? test_q : test_q + 24'h000001;
         SELF_TESTING <= (state_d == msp_pkg::MSP_ST_TEST);
         if (test_done) begin
            MODE           <= mode_sw;
            BAUD_SEL       <= baud_sw;
            FRAME_INTERNAL <= frame_int_sw;
            FRAME_ODD_7BIT <= frame_alt_sw;
         end
      end
   end

   // ---------------------------------------------------------------
   // stability qualifier and scan timer
   // ---------------------------------------------------------------
   logic [19:0] prev_q;
   logic [23:0] stab_q, scan_q;
   logic        taken_q;
   wire         port_chg  = (act != prev_q);
   wire         qualified = (stab_q >= QUAL_CNT);
   wire         scan_tick = (scan_q == SCAN_TOP);

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         prev_q <= 20'h00000;
         stab_q <= 24'h000000;
         scan_q <= 24'h000000;
      end else begin
         prev_q <= act;
         stab_q <= port_chg ? 24'h000000 : (qualified ? stab_q : stab_q + 24'h000001);
         scan_q <= scan_tick ? 24'h000000 : scan_q + 24'h000001;
      end
   end

   // ---------------------------------------------------------------
   // polarity, weighting and steering
   // ---------------------------------------------------------------
   wire [19:0] lvl      = act ^ {20{CFG_INVERT}};
   wire [15:0] sel      = lvl[15:0] & (CFG_WIDE16 ? 16'hFFFF : 16'h00FF);
   wire        ctl_idle = (act[19:16] == 4'h0);
   wire        hold     = lvl[`MSP_PIN_HOLD];
   wire        is_msg   = lvl[`MSP_PIN_MSGDATA];
   wire [1:0]  set_idx  = {lvl[`MSP_PIN_SET2], lvl[`MSP_PIN_SET1]};

   wire bcd_bad = digit_bad(sel[3:0]) || digit_bad(sel[7:4]) ||
                  digit_bad(sel[11:8]) || digit_bad(sel[15:12]);
   wire [15:0] bcd_val = 16'(sel[3:0]) + 16'(sel[7:4]) * 16'h000A +
                         16'(sel[11:8]) * 16'h0064 + 16'(sel[15:12]) * 16'h03E8;
   wire [15:0] value   = CFG_BCD ? bcd_val : sel;
   wire        val_ok  = CFG_BCD ? !bcd_bad : 1'b1;
   // upper message limit only bites for 16-bit binary
   wire        msg_ok  = val_ok && (value <= `MSP_MSG_MAX_BIN);

   wire display = (state_q == msp_pkg::MSP_ST_RUN) && (MODE == msp_pkg::MSP_MODE_DISPLAY);
   // stability count is still the old value's in the cycle the port moves: block that cycle
   wire accept  = display && scan_tick && qualified && !port_chg && !taken_q &&
                  !ctl_idle && hold;
   wire msg_go  = accept && is_msg && msg_ok;
   wire data_go = accept && !is_msg && val_ok;

   // one acceptance per stable value; a change re-arms it
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         taken_q  <= 1'b0;
         MSG_NUM  <= 16'h0000;
         MSG_STB  <= 1'b0;
         DATA_VAL <= 16'h0000;
         DATA_SET <= 2'h0;
         DATA_STB <= 1'b0;
      end else begin
         taken_q  <= accept || (taken_q && !port_chg);
         MSG_STB  <= msg_go;
         DATA_STB <= data_go;
         if (msg_go) begin
            MSG_NUM <= value;
         end
         if (data_go) begin
            DATA_VAL <= value;
            DATA_SET <= set_idx;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_strobe_exclusive: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      !(MSG_STB && DATA_STB))
      else $error("message and data strobes together");

   chk_display_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (MSG_STB || DATA_STB) |-> (MODE == msp_pkg::MSP_MODE_DISPLAY) && !SELF_TESTING)
      else $error("port value taken outside display mode");

   chk_hold_needed: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (MSG_STB || DATA_STB) |-> $past(hold) && !$past(ctl_idle))
      else $error("value taken without hold");

   chk_stable_time: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (MSG_STB || DATA_STB) |-> $past(stab_q) >= QUAL_CNT && $past(scan_tick) && !$past(port_chg))
      else $error("value taken before stable period");

   chk_set_route: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      DATA_STB |-> DATA_SET == $past(set_idx) && !$past(is_msg))
      else $error("data set steering wrong");

   chk_bcd_limit: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      MSG_STB && $past(CFG_BCD) |-> !$past(bcd_bad) && MSG_NUM <= 16'h270F)
      else $error("bad bcd digit accepted");

   chk_change_restart: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      port_chg |=> stab_q == 24'h000000 && !MSG_STB && !DATA_STB ##1 !MSG_STB && !DATA_STB)
      else $error("stability count not restarted");

   chk_mode_frozen: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      !SELF_TESTING && $past(!SELF_TESTING) |-> $stable(MODE) && $stable(BAUD_SEL))
      else $error("mode changed without restart");

   chk_selftest_len: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      $fell(SELF_TESTING) |-> $past(test_q) == TEST_TOP)
      else $error("self test length wrong");

   chk_baud_internal: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      !SELF_TESTING && BAUD_SEL == msp_pkg::MSP_BAUD_INTERNAL |-> FRAME_INTERNAL && !FRAME_ODD_7BIT)
      else $error("internal rate without internal frame");

endmodule

// ==== hdl/msp_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the select port decoder
// Assumes: 10 MHz system clock
// Notes:   times are in microseconds, counts derived from them
//
// Function
// - at restart, switch positions 1-3 choose one of seven operating modes
// - positions 4,5 choose 300 baud, 1200 baud, or internally stored rate
// - with position 5 off, position 8 picks 8N1 or 7-bit odd two-stop frame
// - restart runs a self-test phase, then enters switch mode; switch read only then
// - port input accepted only in display mode; 8 or 16 selects plus 4 controls
// - active input reads 1 non-inverted, 0 inverted
// - BCD weights give 2 or 4 decimal digits, 0-99 or 0-9999
// - binary weights powers of two; messages limited 0-255 or 0-9999
// - port value accepted only while hold control reads 1
// - value valid only after stable one scan interval plus debounce time
// - message-or-data control 1 means message number, 0 means variable data
// - set-select inputs ignored for message numbers
// - set-select pair 00..11 steers data to set 1..4
// - port sampled at fixed scan interval; ignored when all four control pins are low, in either polarity
// - newly accepted message number replaces the current one at once
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH

`define MSP_CLK_MHZ      10
`define MSP_SCAN_US      1000
`define MSP_DEBOUNCE_US  10000
`define MSP_SELFTEST_US  100000
`define MSP_SCAN_CYC     (`MSP_SCAN_US * `MSP_CLK_MHZ)
`define MSP_DEBOUNCE_CYC (`MSP_DEBOUNCE_US * `MSP_CLK_MHZ)
`define MSP_SELFTEST_CYC (`MSP_SELFTEST_US * `MSP_CLK_MHZ)

// switch positions, position 1 in bit 0
`define MSP_SW_MODE_LO   0
`define MSP_SW_MODE_HI   2
`define MSP_SW_BAUD_1200 3
`define MSP_SW_BAUD_INT  4
`define MSP_SW_FRAME     7

// port pin vector: selects in 15:0, then controls
`define MSP_PIN_HOLD     16
`define MSP_PIN_MSGDATA  17
`define MSP_PIN_SET1     18
`define MSP_PIN_SET2     19

`define MSP_MSG_MAX_BIN  16'h270F
`define MSP_MODE_RST     3'h0

`endif

// ==== hdl/msp_pkg.sv ====
// Purpose: types of the select port decoder
// Assumes: nothing
// Notes:   mode codes follow switch positions {3,2,1}
package msp_pkg;
   typedef enum logic [1:0] {
      MSP_ST_TEST = 2'b01,
      MSP_ST_RUN  = 2'b10
   } msp_state_e;

   typedef enum logic [2:0] {
      MSP_MODE_DISPLAY  = 3'h0,
      MSP_MODE_PROGRAM  = 3'h1,
      MSP_MODE_TAPE_IN  = 3'h2,
      MSP_MODE_TAPE_OUT = 3'h3,
      MSP_MODE_VERIFY   = 3'h4,
      MSP_MODE_PRINT    = 3'h5,
      MSP_MODE_DISPTEST = 3'h6,
      MSP_MODE_UNUSED   = 3'h7
   } msp_mode_e;

   typedef enum logic [1:0] {
      MSP_BAUD_300      = 2'h0,
      MSP_BAUD_1200     = 2'h1,
      MSP_BAUD_INTERNAL = 2'h2
   } msp_baud_e;
endpackage

// ==== testbench/msp_ctl_model.sv ====
// Purpose: controller model driving the select port and control pins
// Assumes: pins change only at falling clock edges
// Notes:   takes logic values, puts out current levels for the set polarity
`timescale 1ns/10ps

module msp_ctl_model (
   input  wire logic        clk,
   input  wire logic        invert,
   output logic      [15:0] pins,
   output logic             hold,
   output logic             msg_data,
   output logic             sel1,
   output logic             sel2
);
   initial begin
      {pins, hold, msg_data, sel2, sel1} = 20'h00000;
   end

   // c is {hold, message-or-data, set select 2, set select 1}
   // pins then stay put until the next call, so each value is held stable
   task automatic present(input logic [15:0] v, input logic [3:0] c);
      @(negedge clk);
      {hold, msg_data, sel2, sel1} = c ^ {4{invert}};
      pins = v ^ {16{invert}};
   endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the select port decoder
// Assumes: short simulation counts for scan, debounce and self test
// Notes:   inputs change at falling edges, outputs are read there too
`timescale 1ns/10ps

module testbench;
   logic               clk_sys = 1'b0;
   logic               rst_b = 1'b0;
   logic [7:0]         sw = 8'h00;
   logic               wide = 1'b1;
   logic               inv = 1'b0;
   logic               bcd = 1'b0;
   logic [15:0]        pins;
   logic               hold, mdat, s1, s2, st, mstb, dstb, fint, fodd;
   msp_pkg::msp_mode_e mode;
   msp_pkg::msp_baud_e baud;
   logic [15:0]        mnum;
   logic [15:0]        dval;
   logic [1:0]         dset;
   int                 num_errors = 0;
   int                 n_compared = 0;

   always #50 clk_sys = ~clk_sys;

   msp_ctl_model ctl (.clk(clk_sys), .invert(inv), .pins(pins), .hold(hold),
      .msg_data(mdat), .sel1(s1), .sel2(s2));

   msp_decoder #(.SCAN_CYC(8), .DEBOUNCE_CYC(16), .SELFTEST_CYC(20)) dut (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .CONFIG_DIP_SWITCH(sw), .SELECT_BIT(pins),
      .CTRL_HOLD(hold), .CTRL_MSG_DATA(mdat), .CTRL_SET_SEL1(s1), .CTRL_SET_SEL2(s2),
      .CFG_WIDE16(wide), .CFG_INVERT(inv), .CFG_BCD(bcd), .SELF_TESTING(st),
      .MODE(mode), .BAUD_SEL(baud), .FRAME_INTERNAL(fint), .FRAME_ODD_7BIT(fodd),
      .MSG_NUM(mnum), .MSG_STB(mstb), .DATA_VAL(dval), .DATA_SET(dset), .DATA_STB(dstb));

   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // idle the port first so a stale value cannot be taken after restart
   task automatic restart(input logic [7:0] s);
      int n;
      ctl.present(16'h0000, 4'h0);
      sw = s;
      rst_b = 1'b0;
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      n = 0;
      while (st !== 1'b0 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 60) begin
         num_errors++;
         tally_and_finish();
      end
      cmp("selftest long", {15'h0, n >= 18}, 16'h0001);
      cmp("mode", {13'h0, s[2:0]}, {13'h0, mode});
      cmp("baud", s[4] ? 16'h0002 : {15'h0, s[3]}, {14'h0, baud});
      cmp("frame internal", {15'h0, s[4]}, {15'h0, fint});
      if (!s[4]) cmp("frame odd", {15'h0, s[7]}, {15'h0, fodd});
      sw = ~s;
      repeat (10) @(negedge clk_sys);
      cmp("mode kept", {13'h0, s[2:0]}, {13'h0, mode});
   endtask

   // kind: 0 refused, 1 message, 2 data
   task automatic send(input logic [15:0] v, input logic [3:0] c, input int kind,
                       input logic [15:0] ev, input logic [1:0] es);
      int n;
      int seen;
      ctl.present(v, c);
      n = 0;
      while (mstb !== 1'b1 && dstb !== 1'b1 && n < 80) begin
         @(negedge clk_sys);
         n++;
      end
      seen = (mstb === 1'b1) ? 1 : (dstb === 1'b1) ? 2 : 0;
      cmp("strobe kind", kind[15:0], seen[15:0]);
      if (seen != 0) begin
         cmp("stable wait", {15'h0, n >= 24}, 16'h0001);
         if (seen == 1) cmp("msg num", ev, mnum);
         if (seen == 2) cmp("data val", ev, dval);
         if (seen == 2) cmp("data set", {14'h0, es}, {14'h0, dset});
         @(negedge clk_sys);
         cmp("strobe width", 16'h0000, {14'h0, mstb, dstb});
      end
   endtask

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      for (int i = 0; i < 8; i++) begin
         restart({i[0], 2'b00, i[2], i[1], i[2:0]});
      end
      restart(8'h00);
      send(16'd1234, 4'b1111, 1, 16'd1234, 2'h0);
      send(16'd9999, 4'b1100, 1, 16'd9999, 2'h0);
      send(16'd10000, 4'b1100, 0, 16'h0000, 2'h0);
      for (int k = 0; k < 4; k++) begin
         send(16'hFFFF - k[15:0], {2'b10, k[1:0]}, 2, 16'hFFFF - k[15:0], k[1:0]);
      end
      send(16'd55, 4'b0100, 0, 16'h0000, 2'h0);
      bcd = 1'b1;
      send(16'h9876, 4'b1100, 1, 16'd9876, 2'h0);
      send(16'h00A1, 4'b1100, 0, 16'h0000, 2'h0);
      send(16'h0042, 4'b1001, 2, 16'd42, 2'h1);
      bcd = 1'b0;
      wide = 1'b0;
      send(16'hAB12, 4'b1100, 1, 16'h0012, 2'h0);
      wide = 1'b1;
      inv = 1'b1;
      send(16'd300, 4'b1100, 1, 16'd300, 2'h0);
      send(16'd7, 4'b1111, 0, 16'h0000, 2'h0);
      inv = 1'b0;
      restart(8'h01);
      send(16'd12, 4'b1100, 0, 16'h0000, 2'h0);
      tally_and_finish();
   end
endmodule
